// File: rtl/rsb_params.svh
// Purpose: Named constants for the reset source and break status bank
// Assumes: 32-bit classic Wishbone, one register per aligned word
// Notes: Definitions only
`ifndef RSB_PARAMS_SVH
`define RSB_PARAMS_SVH

// Register word indices (byte address is four times the index)
`define RSB_IDX_BREAK_WAIT 6'h00
`define RSB_IDX_RESET_SOURCE 6'h01
`define RSB_IDX_BREAK_CONTROL 6'h02

// Address and lane positions
`define RSB_ADR_HI 7
`define RSB_ADR_LO 2
`define RSB_LANE0 0

// Break wait status fields
`define RSB_WAIT_FLAG_BIT 1

// Reset source status fields
`define RSB_SRC_COUNT 6
`define RSB_SRC_LOW_VOLT 0
`define RSB_SRC_BAD_ADDR 1
`define RSB_SRC_BAD_OP 2
`define RSB_SRC_WDOG 3
`define RSB_SRC_PIN 4
`define RSB_SRC_POR 5
`define RSB_SRC_LSB 2

// Break flag control fields
`define RSB_CLEAR_EN_BIT 7

// Reset values
`define RSB_SRC_RESET 6'h20
`define RSB_SRC_NONE 6'h00
`define RSB_WAIT_FLAG_RESET 1'b0
`define RSB_CLEAR_EN_RESET 1'b0
`define RSB_DATA_ZERO 32'h0000_0000

`endif

// File: rtl/rsb_pkg.sv
// Purpose: Types shared by the reset source and break status bank
// Assumes: Constants live in rsb_params.svh
// Notes: Gray coded bus handshake states
package rsb_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } bus_state_type;

endpackage

// File: rtl/wb_reg_port.sv
// Purpose: Classic Wishbone slave handshake for a small register bank
// Assumes: Master holds the request until it sees ack
// Notes: Ack comes one cycle after the request is seen
`timescale 1ns/1ns
`include "rsb_params.svh"

module wb_reg_port (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Bus request
    input wire logic wbCyc,
    input wire logic wbStb,
    // Bus answer
    output logic wbAck,
    // Decoded access
    output logic accessStrobe
);

    rsb_pkg::bus_state_type state;
    rsb_pkg::bus_state_type next_state;
    logic request;

    assign request = wbCyc & wbStb;
    assign accessStrobe = (state == rsb_pkg::BUS_IDLE) & request;
    assign next_state = accessStrobe ? rsb_pkg::BUS_ACK : rsb_pkg::BUS_IDLE;
    assign wbAck = (state == rsb_pkg::BUS_ACK);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= rsb_pkg::BUS_IDLE;
        end else begin
            state <= next_state;
        end
    end

endmodule // wb_reg_port

// File: rtl/clear_step_guard.sv
// Purpose: Two-step flag clear sequencer honouring break protection
// Assumes: Step inputs are one-cycle pulses on the same clock
// Notes: An armed first step survives break entry and exit
`timescale 1ns/1ns

module clear_step_guard (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Steps and permission
    input wire logic stepOne,
    input wire logic stepTwo,
    input wire logic clearAllowed,
    // Result
    output logic clearPulse,
    output logic armed
);

    logic next_armed;
    logic next_clear;

    assign next_clear = armed & stepTwo & clearAllowed;
    assign next_armed = stepOne | (armed & ~next_clear);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            armed <= 1'b0;
            clearPulse <= 1'b0;
        end else begin
            armed <= next_armed;
            clearPulse <= next_clear;
        end
    end

endmodule // clear_step_guard

// File: rtl/reset_source_and_break_status.sv
// Purpose: Reset source, break wait and break flag control registers
// Assumes: Reset is power-on; other reset sources arrive as event inputs
// Notes: Registers sit at word offsets on a classic Wishbone slave
`timescale 1ns/1ns
`include "rsb_params.svh"

module reset_source_and_break_status (
    // Clock and power-on reset
    input wire logic clock,
    input wire logic reset,
    // Wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatIn,
    output logic [31:0] wbDatOut,
    output logic wbAck,
    // Reset sources
    input wire logic externalResetPin_n,
    input wire logic watchdogTimeout,
    input wire logic illegalOpcode,
    input wire logic illegalAddress,
    input wire logic accessIsFetch,
    input wire logic lowVoltageTrip,
    // Break and wait
    input wire logic breakActive,
    input wire logic breakWakeFromWait,
    // Two-step clear service for other modules
    input wire logic flagStepOne,
    input wire logic flagStepTwo,
    output logic flagTwoStepClear,
    // Status to the system
    output logic breakClearEnableOut,
    output logic statusClearAllowed,
    output logic systemResetRequest
);

    // Decoding
    function automatic logic hitsIndex(input logic [5:0] index, input logic [5:0] target);
        hitsIndex = (index == target);
    endfunction

    logic accessStrobe;
    logic [5:0] regIndex;
    logic readStrobe;
    logic writeStrobe;
    logic lane0Write;
    logic hitBreakWait;
    logic hitResetSource;
    logic hitBreakControl;
    logic pinSync1;
    logic pinSync2;
    logic pinSyncLast;
    logic pinEvent;
    logic fetchFault;
    logic [`RSB_SRC_COUNT-1:0] sourceEvent;
    logic anyEvent;
    logic [`RSB_SRC_COUNT-1:0] resetFlags;
    logic [`RSB_SRC_COUNT-1:0] next_resetFlags;
    logic readClear;
    logic breakWaitFlag;
    logic next_breakWaitFlag;
    logic breakWaitClear;
    logic breakClearEnable;
    logic next_breakClearEnable;
    logic [31:0] readValue;
    logic [31:0] next_wbDatOut;
    logic guardArmed;

    // Power-on value of the six source flags
    localparam logic [`RSB_SRC_COUNT-1:0] SRC_POWER_ON = `RSB_SRC_RESET;

    // Bus handshake
    wb_reg_port busPort (
        .clock(clock),
        .reset(reset),
        .wbCyc(wbCyc),
        .wbStb(wbStb),
        .wbAck(wbAck),
        .accessStrobe(accessStrobe)
    );

    assign regIndex = wbAdr[`RSB_ADR_HI:`RSB_ADR_LO];
    assign readStrobe = accessStrobe & ~wbWe;
    assign writeStrobe = accessStrobe & wbWe;
    assign lane0Write = writeStrobe & wbSel[`RSB_LANE0];
    assign hitBreakWait = hitsIndex(regIndex, `RSB_IDX_BREAK_WAIT);
    assign hitResetSource = hitsIndex(regIndex, `RSB_IDX_RESET_SOURCE);
    assign hitBreakControl = hitsIndex(regIndex, `RSB_IDX_BREAK_CONTROL);

    // Clear permission in break state
    assign statusClearAllowed = ~breakActive | breakClearEnable;
    assign breakClearEnableOut = breakClearEnable;

    // Pin synchroniser and edge detect
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pinSync1 <= 1'b0;
            pinSync2 <= 1'b0;
            pinSyncLast <= 1'b0;
        end else begin
            pinSync1 <= ~externalResetPin_n;
            pinSync2 <= pinSync1;
            pinSyncLast <= pinSync2;
        end
    end

    assign pinEvent = pinSync2 & ~pinSyncLast;
    assign fetchFault = illegalAddress & accessIsFetch;

    // Source event vector
    assign sourceEvent[`RSB_SRC_POR] = 1'b0;
    assign sourceEvent[`RSB_SRC_PIN] = pinEvent;
    assign sourceEvent[`RSB_SRC_WDOG] = watchdogTimeout;
    assign sourceEvent[`RSB_SRC_BAD_OP] = illegalOpcode;
    assign sourceEvent[`RSB_SRC_BAD_ADDR] = fetchFault;
    assign sourceEvent[`RSB_SRC_LOW_VOLT] = lowVoltageTrip;
    assign anyEvent = |sourceEvent;

    // Read clears unless protected; writes never touch the flags
    assign readClear = readStrobe & hitResetSource & statusClearAllowed;

    // Six source flags
    genvar i;
    generate
        for (i = 0; i < `RSB_SRC_COUNT; i = i + 1) begin : gFlag
            assign next_resetFlags[i] = anyEvent ? sourceEvent[i] :
                (readClear ? 1'b0 : resetFlags[i]);
            always_ff @(posedge clock or posedge reset) begin
                if (reset) begin
                    resetFlags[i] <= SRC_POWER_ON[i];
                end else begin
                    resetFlags[i] <= next_resetFlags[i];
                end
            end
        end
    endgenerate

    // Break wait flag
    assign breakWaitClear = lane0Write & hitBreakWait & ~wbDatIn[`RSB_WAIT_FLAG_BIT] &
        statusClearAllowed;
    assign next_breakWaitFlag = anyEvent ? `RSB_WAIT_FLAG_RESET :
        (breakWakeFromWait ? 1'b1 :
        (breakWaitClear ? 1'b0 : breakWaitFlag));

    // Break clear enable
    assign next_breakClearEnable = anyEvent ? `RSB_CLEAR_EN_RESET :
        ((lane0Write & hitBreakControl) ? wbDatIn[`RSB_CLEAR_EN_BIT] :
        breakClearEnable);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            breakWaitFlag <= `RSB_WAIT_FLAG_RESET;
            breakClearEnable <= `RSB_CLEAR_EN_RESET;
            systemResetRequest <= 1'b0;
        end else begin
            breakWaitFlag <= next_breakWaitFlag;
            breakClearEnable <= next_breakClearEnable;
            systemResetRequest <= anyEvent;
        end
    end

    // Read data
    assign readValue = hitBreakWait ? (32'(breakWaitFlag) << `RSB_WAIT_FLAG_BIT) :
        hitResetSource ? (32'(resetFlags) << `RSB_SRC_LSB) :
        hitBreakControl ? (32'(breakClearEnable) << `RSB_CLEAR_EN_BIT) :
        `RSB_DATA_ZERO;
    assign next_wbDatOut = readStrobe ? readValue : wbDatOut;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wbDatOut <= `RSB_DATA_ZERO;
        end else begin
            wbDatOut <= next_wbDatOut;
        end
    end

    // Two-step clear for other modules
    clear_step_guard stepGuard (
        .clock(clock),
        .reset(reset),
        .stepOne(flagStepOne),
        .stepTwo(flagStepTwo),
        .clearAllowed(statusClearAllowed),
        .clearPulse(flagTwoStepClear),
        .armed(guardArmed)
    );

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    a_wait_exit_set: assert property (
        breakWakeFromWait && !anyEvent |=> breakWaitFlag)
        else $error("Break wait flag not set after break wake");

    a_wait_hold_low: assert property (
        !breakWaitFlag && !breakWakeFromWait |=> !breakWaitFlag)
        else $error("Break wait flag set without break wake");

    a_wait_write_clear: assert property (
        lane0Write && hitBreakWait && !wbDatIn[`RSB_WAIT_FLAG_BIT] && statusClearAllowed
        && !breakWakeFromWait |=> !breakWaitFlag)
        else $error("Break wait flag not cleared by zero write");

    a_wait_reset_clear: assert property (
        anyEvent |=> !breakWaitFlag && !breakClearEnable)
        else $error("Reset event did not clear break bits");

    a_source_onehot: assert property (
        anyEvent |=> resetFlags == $past(sourceEvent))
        else $error("Source flags differ from reset events");

    a_read_clears: assert property (
        readClear && !anyEvent |=> resetFlags == `RSB_SRC_NONE)
        else $error("Source flags not cleared by read");

    a_read_returns: assert property (
        readStrobe && hitResetSource |=>
        wbDatOut[`RSB_SRC_LSB +: `RSB_SRC_COUNT] == $past(resetFlags) && wbAck)
        else $error("Read did not return flags before clearing");

    a_pin_flag: assert property (
        $rose(pinSync2) |=> resetFlags[`RSB_SRC_PIN] && !resetFlags[`RSB_SRC_POR])
        else $error("Pin reset flag not set");

    a_pin_delay: assert property (
        $fell(externalResetPin_n) ##1 !externalResetPin_n [*3] |->
        resetFlags[`RSB_SRC_PIN] || $past(readClear) || anyEvent || $past(anyEvent))
        else $error("Pin reset not seen within three cycles");

    a_wdog_flag: assert property (
        watchdogTimeout |=> resetFlags[`RSB_SRC_WDOG])
        else $error("Watchdog flag not set");

    a_opcode_flag: assert property (
        illegalOpcode |=> resetFlags[`RSB_SRC_BAD_OP])
        else $error("Illegal opcode flag not set");

    a_fetch_flag: assert property (
        illegalAddress && accessIsFetch |=> resetFlags[`RSB_SRC_BAD_ADDR])
        else $error("Illegal address fetch flag not set");

    a_data_ignored: assert property (
        illegalAddress && !accessIsFetch && !resetFlags[`RSB_SRC_BAD_ADDR] |=>
        !resetFlags[`RSB_SRC_BAD_ADDR])
        else $error("Data access set illegal address flag");

    a_low_volt_flag: assert property (
        lowVoltageTrip |=> resetFlags[`RSB_SRC_LOW_VOLT])
        else $error("Low-voltage flag not set");

    a_enable_readback: assert property (
        readStrobe && hitBreakControl |=>
        wbAck && wbDatOut[`RSB_CLEAR_EN_BIT] == $past(breakClearEnable))
        else $error("Clear enable readback mismatch");

    a_enable_store: assert property (
        lane0Write && hitBreakControl && !anyEvent |=>
        breakClearEnable == $past(wbDatIn[`RSB_CLEAR_EN_BIT]))
        else $error("Clear enable not written");

    a_break_protect: assert property (
        breakActive && !breakClearEnable && readStrobe && hitResetSource && !anyEvent
        |=> resetFlags == $past(resetFlags))
        else $error("Flags cleared in protected break state");

    a_break_stays: assert property (
        $fell(breakActive) && !$past(anyEvent) && !$past(readClear) &&
        !$past(breakWaitClear) && !$past(breakWakeFromWait) |->
        $stable(resetFlags) && $stable(breakWaitFlag))
        else $error("Cleared flag came back after break");

    a_two_step_hold: assert property (
        guardArmed && flagStepTwo && breakActive && !breakClearEnable |=>
        guardArmed && !flagTwoStepClear)
        else $error("Two-step clear completed in protected break");

    a_two_step_done: assert property (
        guardArmed && flagStepTwo && !breakActive |=> flagTwoStepClear)
        else $error("Two-step clear did not complete after break");

    a_write_ignored: assert property (
        writeStrobe && hitResetSource && !anyEvent |=> resetFlags == $past(resetFlags))
        else $error("Write changed source flags");

    a_ack_one_cycle: assert property (
        accessStrobe |=> wbAck ##1 !wbAck)
        else $error("Ack not a single cycle pulse");

    c_read_clear: cover property (readClear ##1 resetFlags == `RSB_SRC_NONE);
    c_break_wake: cover property (breakWakeFromWait ##1 breakWaitFlag);
    c_protected_read: cover property (breakActive && !breakClearEnable && readStrobe);
    c_two_step: cover property (flagStepOne ##[1:20] flagTwoStepClear);

endmodule // reset_source_and_break_status

// File: dv/reset_event_model.sv
// Purpose: Far-side model of the reset sources and break logic
// Assumes: Bench asks for one event at a time with a one-cycle fire pulse
// Notes: Reset pin idles high through its pull-up and is held low for four cycles
`timescale 1ns/1ns

module reset_event_model (
    // Clock
    input wire logic clock,
    // Bench command
    input wire logic fire,
    input wire logic [2:0] kind,
    // Events toward the block
    output logic externalResetPin_n,
    output logic watchdogTimeout,
    output logic illegalOpcode,
    output logic illegalAddress,
    output logic accessIsFetch,
    output logic lowVoltageTrip,
    output logic breakWakeFromWait
);
    logic [2:0] pinCount = 3'h0;
    logic [6:0] pulse = 7'h00;

    always @(posedge clock) begin
        pulse <= fire ? 7'h01 << kind : 7'h00;
        if (fire && kind == 3'h0) begin
            pinCount <= 3'h4;
        end else if (pinCount != 3'h0) begin
            pinCount <= pinCount - 3'h1;
        end
    end

    // Kinds 3 and 4 differ only in the fetch qualifier
    assign externalResetPin_n = (pinCount == 3'h0);
    assign watchdogTimeout = pulse[1];
    assign illegalOpcode = pulse[2];
    assign illegalAddress = pulse[3] | pulse[4];
    assign accessIsFetch = pulse[3];
    assign lowVoltageTrip = pulse[5];
    assign breakWakeFromWait = pulse[6];
endmodule // reset_event_model

// File: dv/tb_top.sv
// Purpose: Self-checking bench for the reset source and break status bank
// Assumes: Registers at 0x00, 0x04, 0x08; one idle cycle between bus requests
// Notes: Event rows first, then break, two-step and reset cases
`timescale 1ns/1ns

module tb_top;
    typedef struct packed {logic [2:0] k; logic [7:0] exp;} row_type;
    logic clock = 1'b0, reset = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatIn = 32'h0, wbDatOut;
    logic wbAck, externalResetPin_n, watchdogTimeout, illegalOpcode, illegalAddress;
    logic accessIsFetch, lowVoltageTrip, breakActive = 1'b0, breakWakeFromWait;
    logic flagStepOne = 1'b0, flagStepTwo = 1'b0, flagTwoStepClear;
    logic breakClearEnableOut, statusClearAllowed, systemResetRequest;
    logic fire = 1'b0;
    logic [2:0] kind = 3'h0;
    int errors = 0, check_count = 0, clearSeen = 0, requestSeen = 0;
    row_type rows[6] = '{'{3'h0, 8'h40}, '{3'h1, 8'h20}, '{3'h2, 8'h10},
        '{3'h3, 8'h08}, '{3'h4, 8'h00}, '{3'h5, 8'h04}};

    always #5 clock = ~clock;
    always @(posedge clock) if (flagTwoStepClear === 1'b1) clearSeen++;
    always @(posedge clock) if (systemResetRequest === 1'b1) requestSeen++;

    reset_event_model i_model (.clock(clock), .fire(fire), .kind(kind),
        .externalResetPin_n(externalResetPin_n), .watchdogTimeout(watchdogTimeout),
        .illegalOpcode(illegalOpcode), .illegalAddress(illegalAddress),
        .accessIsFetch(accessIsFetch), .lowVoltageTrip(lowVoltageTrip),
        .breakWakeFromWait(breakWakeFromWait));

    reset_source_and_break_status i_dut (.clock(clock), .reset(reset), .wbCyc(wbCyc),
        .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
        .wbDatOut(wbDatOut), .wbAck(wbAck), .externalResetPin_n(externalResetPin_n),
        .watchdogTimeout(watchdogTimeout), .illegalOpcode(illegalOpcode),
        .illegalAddress(illegalAddress), .accessIsFetch(accessIsFetch),
        .lowVoltageTrip(lowVoltageTrip), .breakActive(breakActive),
        .breakWakeFromWait(breakWakeFromWait), .flagStepOne(flagStepOne),
        .flagStepTwo(flagStepTwo), .flagTwoStepClear(flagTwoStepClear),
        .breakClearEnableOut(breakClearEnableOut), .statusClearAllowed(statusClearAllowed),
        .systemResetRequest(systemResetRequest));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Classic single cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                      output logic [31:0] rd);
        int n;
        @(posedge clock);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= 4'h1;
        wbDatIn <= {24'h0, dat};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rd = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n >= 20) check("ack", 32'h0, 32'h1);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [31:0] d;
        wb(1'b1, adr, dat, d);
    endtask

    task automatic rdchk(input string name, input logic [7:0] adr, input logic [7:0] exp);
        logic [31:0] d;
        wb(1'b0, adr, 8'h00, d);
        check(name, d, {24'h0, exp});
    endtask

    task automatic ev(input logic [2:0] k);
        @(posedge clock);
        fire <= 1'b1;
        kind <= k;
        @(posedge clock);
        fire <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    task automatic step(input logic two);
        @(posedge clock);
        if (two) flagStepTwo <= 1'b1; else flagStepOne <= 1'b1;
        @(posedge clock);
        flagStepOne <= 1'b0;
        flagStepTwo <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #20000;
        errors++;
        close_out();
    end

    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rdchk("por", 8'h04, 8'h80);
        rdchk("unmapped", 8'h3c, 8'h00);
        foreach (rows[i]) begin
            ev(rows[i].k);
            rdchk("source", 8'h04, rows[i].exp);
            rdchk("cleared", 8'h04, 8'h00);
        end
        check("requests", requestSeen, 5);
        ev(3'h1);
        wr(8'h04, 8'h00);
        rdchk("wr ignored", 8'h04, 8'h20);
        ev(3'h1);
        ev(3'h6);
        rdchk("wake", 8'h00, 8'h02);
        breakActive <= 1'b1;
        wr(8'h00, 8'h00);
        rdchk("bw held", 8'h00, 8'h02);
        rdchk("src held", 8'h04, 8'h20);
        check("allowed", {31'h0, statusClearAllowed}, 32'h0);
        wr(8'h08, 8'h80);
        rdchk("enable", 8'h08, 8'h80);
        check("allowed", {31'h0, statusClearAllowed}, 32'h1);
        wr(8'h00, 8'h00);
        breakActive <= 1'b0;
        rdchk("bw after", 8'h00, 8'h00);
        wr(8'h08, 8'h00);
        step(1'b0);
        breakActive <= 1'b1;
        step(1'b1);
        check("protected", clearSeen, 0);
        breakActive <= 1'b0;
        step(1'b1);
        check("second step", clearSeen, 1);
        ev(3'h6);
        wr(8'h08, 8'h80);
        rdchk("bw set", 8'h00, 8'h02);
        check("en out", {31'h0, breakClearEnableOut}, 32'h1);
        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rdchk("rst bw", 8'h00, 8'h00);
        rdchk("rst en", 8'h08, 8'h00);
        rdchk("rst src", 8'h04, 8'h80);
        check("en out rst", {31'h0, breakClearEnableOut}, 32'h0);
        check("req rst", {31'h0, systemResetRequest}, 32'h0);
        close_out();
    end
endmodule // tb_top
